// ===== src/nsl_map.svh
/*
 Constants of the node state and status LED controller: register offsets,
 command codes, field positions, the invalid source code and timing figures.
 Assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus.
*/
// Summary of operation
// RULE1: While charge current flows, blink yellow with a 4 second pattern.
// RULE2: At full charge show solid green until taken off the charger.
// RULE3: In shelf mode, a bump or charging supply at the contacts wakes the node.
// RULE4: Deployed: record, cycle positioning receiver, lock clock, broadcast status.
// RULE5: Undeployed: no recording, receiver low power, clock unlocked, still broadcast.
// RULE6: An accepted bump wake blinks white exactly once for 1 sec.
// RULE7: Remember deployed or undeployed at shelving and return there on wake.
// RULE8: A brief DC voltage at the contacts while shelved is a bump wake request.
// RULE9: A failed deploy or undeploy blinks red five times, 1 sec each.
// RULE10: Deploy or undeploy may come from offload, programming link or field tool.
// RULE11: Shelf power-off may come from offload, programming link or field tool.
// RULE12: A passed sensor test while deployed shows green, meaning recording.
// RULE13: Failure patterns beat informational ones; all blinks timed from the clock.
// RULE14: A forever pattern lasts until reset and no later event clears it.
`ifndef NSL_MAP_SVH
`define NSL_MAP_SVH
`define NSL_OFS_CMD 8'h00
`define NSL_OFS_STAT 8'h04
`define NSL_CMD_NONE 2'h0
`define NSL_CMD_DEPLOY 2'h1
`define NSL_CMD_UNDEPLOY 2'h2
`define NSL_CMD_SHELF 2'h3
`define NSL_SRC_BAD 2'h3
`define NSL_CMD_CODE_LSB 0
`define NSL_CMD_SRC_LSB 2
`define NSL_CLK_NS 5
`define NSL_MS_NS 1000000
`define NSL_BLINK_MS 10'd1000
`define NSL_CHG_MS 13'd4000
`define NSL_ERR_MS 13'd2000
`define NSL_FREE_WRAP 13'd7999
`define NSL_RED_PHASES 4'ha
`endif

// ===== src/nsl_pkg.sv
/*
 Types of the node state and status LED controller.
 Assumes nsl_map.svh for every numeric constant.
*/
package nsl_pkg;
   typedef enum logic [1:0] {
      NSL_SHELF,
      NSL_UNDEP,
      NSL_DEP
   } nsl_state_t;
endpackage

// ===== src/nsl_ctrl.sv
/*
 Node power state control and status LED driver with an AHB-Lite slave.
 Assumes contact voltage, charge current and charge-full pins are asynchronous,
 and that test_pass, node_error and cmd_reject come from logic on hclk.
*/
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "nsl_map.svh"

module nsl_ctrl
   import nsl_pkg::*;
#(
   parameter int TICK_CYCLES = `NSL_MS_NS / `NSL_CLK_NS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic contact_volt,
   input wire logic charge_cur,
   input wire logic charge_full,
   input wire logic test_pass,
   input wire logic node_error,
   input wire logic cmd_reject,
   output logic power_hold,
   output logic record_en,
   output logic gps_cycle_en,
   output logic clock_lock_en,
   output logic status_bcast_en,
   output logic led_green,
   output logic led_white,
   output logic led_yellow,
   output logic led_red
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration check: the millisecond divider needs at least two cycles.
   if (TICK_CYCLES < 2) begin : g_chk
      $error("TICK_CYCLES must be at least 2");
   end

   typedef struct packed {
      nsl_state_t st;
      nsl_state_t saved;
      logic [1:0] cv;
      logic [1:0] cc;
      logic [1:0] cf;
      logic cv_prev;
      logic full_seen;
      logic green_rec;
      logic err_hold;
      logic [3:0] red_ph;
      logic [9:0] red_ms;
      logic [9:0] white_ms;
      logic [12:0] free_ms;
      logic [31:0] tick;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic [7:0] fails;
      logic [1:0] last_src;
      logic [3:0] leds;
   } nsl_regs_t;

   nsl_regs_t r;
   nsl_regs_t next_r;
   logic tick_hit;
   logic wake_ev;
   logic bump_ev;
   logic fail_ev;
   logic shelf_ev;
   logic move_ev;
   logic red_busy;
   logic err_on;
   logic addr_ok;
   logic [1:0] cmd_code;
   logic [1:0] cmd_src;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic. Later assignments override earlier ones, so events
   // that start a pattern win over the millisecond countdown of that pattern.
   always_comb begin
      next_r = r;
      cmd_code = hwdata[`NSL_CMD_CODE_LSB +: 2];
      cmd_src = hwdata[`NSL_CMD_SRC_LSB +: 2];
      fail_ev = 1'b0;
      shelf_ev = 1'b0;
      move_ev = 1'b0;
      red_busy = r.err_hold | (r.red_ph != 4'h0);
      // Blinks are timed from a one-cycle millisecond enable. [RULE13]
      tick_hit = (r.tick == 32'(TICK_CYCLES - 1));
      next_r.tick = tick_hit ? 32'h0 : r.tick + 32'h1;
      // Pins pass two flip-flops; only the second stage is looked at.
      next_r.cv = {r.cv[0], contact_volt};
      next_r.cc = {r.cc[0], charge_cur};
      next_r.cf = {r.cf[0], charge_full};
      next_r.cv_prev = r.cv[1];
      // A rising contact voltage while shelved counts if it is high at a clock edge, however short it is. [RULE8]
      wake_ev = (r.st == NSL_SHELF) && r.cv[1] && !r.cv_prev;
      bump_ev = wake_ev && !r.cc[1];

      // Millisecond counters for the free-running and one-shot patterns.
      if (tick_hit) begin
         next_r.free_ms = (r.free_ms == `NSL_FREE_WRAP) ? 13'h0 : r.free_ms + 13'h1;
         if (r.white_ms != 10'h0) begin
            next_r.white_ms = r.white_ms - 10'h1;
         end
         if (r.red_ph != 4'h0) begin
            if (r.red_ms == `NSL_BLINK_MS - 10'h1) begin
               next_r.red_ms = 10'h0;
               next_r.red_ph = r.red_ph - 4'h1; // [RULE9]
            end else begin
               next_r.red_ms = r.red_ms + 10'h1;
            end
         end
      end

      // Address phase: reads are answered at once from a registered word.
      addr_ok = hsel && hready && htrans[1];
      if (hready) begin
         next_r.wr_pend = addr_ok && hwrite;
         next_r.wr_addr = haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            `NSL_OFS_CMD: next_r.rdata = {28'h0, r.last_src, 2'h0};
            `NSL_OFS_STAT: next_r.rdata = {8'h0, 4'h0, r.leds, r.fails, r.full_seen,
               red_busy, r.err_hold, r.green_rec, 2'(r.saved), 2'(r.st)};
            default: next_r.rdata = 32'h0;
         endcase
      end

      // Data phase of a command write: host links and field tool share it.
      if (r.wr_pend && (r.wr_addr == `NSL_OFS_CMD) && (r.st != NSL_SHELF)) begin
         next_r.last_src = cmd_src;
         case (cmd_code)
            `NSL_CMD_SHELF: begin
               shelf_ev = (cmd_src != `NSL_SRC_BAD);
               if (shelf_ev) begin
                  next_r.saved = r.st; // [RULE7]
                  next_r.st = NSL_SHELF; // [RULE11]
               end
            end
            `NSL_CMD_DEPLOY, `NSL_CMD_UNDEPLOY: begin
               if ((cmd_src == `NSL_SRC_BAD) || cmd_reject) begin
                  fail_ev = 1'b1;
                  next_r.fails = r.fails + 8'h1;
                  next_r.red_ph = `NSL_RED_PHASES; // [RULE9]
                  next_r.red_ms = 10'h0;
               end else begin
                  move_ev = 1'b1;
                  next_r.st = (cmd_code == `NSL_CMD_DEPLOY) ? NSL_DEP : NSL_UNDEP; // [RULE10]
               end
            end
            default: begin
            end
         endcase
      end

      // Wake from shelf by bump or charger, back into the saved state.
      if (wake_ev) begin
         next_r.st = r.saved; // [RULE3] [RULE7]
         if (bump_ev) begin
            next_r.white_ms = `NSL_BLINK_MS; // [RULE6]
         end
      end

      // Recording indication follows a passed sensor test while deployed.
      if ((r.st == NSL_DEP) && test_pass) begin
         next_r.green_rec = 1'b1; // [RULE12]
      end
      if (next_r.st != NSL_DEP) begin
         next_r.green_rec = 1'b0;
      end

      // Full charge latches until the contacts lose their supply.
      if (r.cf[1]) begin
         next_r.full_seen = 1'b1;
      end
      if (!r.cv[1]) begin
         next_r.full_seen = 1'b0; // [RULE2]
      end

      // The error pattern is sticky: only reset removes it.
      if (node_error) begin
         next_r.err_hold = 1'b1; // [RULE14]
      end

      // LED mixing: any red pattern blanks the informational colours, so a
      // white bump blink that coincides with a failure is not shown.
      err_on = (r.free_ms < `NSL_ERR_MS) ||
         ((r.free_ms >= 2 * `NSL_ERR_MS) && (r.free_ms < 3 * `NSL_ERR_MS));
      next_r.leds[3] = r.err_hold ? err_on : ((r.red_ph != 4'h0) && !r.red_ph[0]); // [RULE13]
      next_r.leds[2] = !red_busy && r.cc[1] && !r.full_seen &&
         (r.free_ms < `NSL_CHG_MS); // [RULE1]
      next_r.leds[1] = !red_busy && (r.white_ms != 10'h0); // [RULE6]
      next_r.leds[0] = !red_busy && (r.full_seen || r.green_rec); // [RULE2] [RULE12]
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; the node powers up undeployed with nothing lit.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.st <= NSL_UNDEP;
         r.saved <= NSL_UNDEP;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs. The bus never waits and never errors.
   assign hrdata = r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign power_hold = (r.st != NSL_SHELF);
   assign record_en = (r.st == NSL_DEP); // [RULE4] [RULE5]
   assign gps_cycle_en = (r.st == NSL_DEP);
   assign clock_lock_en = (r.st == NSL_DEP);
   assign status_bcast_en = (r.st != NSL_SHELF);
   assign {led_red, led_yellow, led_white, led_green} = r.leds;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the design's own behaviour.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_fail_start;
      fail_ev ##1 (r.red_ph == `NSL_RED_PHASES) && (r.red_ms == 10'h0);
   endsequence

   sequence s_bump_start;
      bump_ev ##1 (r.white_ms == `NSL_BLINK_MS);
   endsequence

   wake_restore_a: assert property (wake_ev |=> r.st == $past(r.saved)) // [RULE3]
      else $error("wake did not restore saved state");
   bump_once_a: assert property (s_bump_start |-> r.st != NSL_SHELF) // [RULE6]
      else $error("bump blink without leaving shelf");
   bump_pulse_a: assert property (bump_ev |=> !$past(r.cc[1]) && power_hold) // [RULE8]
      else $error("bump accepted while charge current flowed");
   shelf_save_a: assert property (shelf_ev |=> r.st == NSL_SHELF && r.saved == $past(r.st)) // [RULE11]
      else $error("shelf did not save state");
   fail_red_a: assert property (s_fail_start |-> ##1 (r.red_ph == `NSL_RED_PHASES)) // [RULE9]
      else $error("red failure pattern did not start");
   deploy_set_a: assert property (move_ev |=> r.st ==
      (($past(hwdata[`NSL_CMD_CODE_LSB +: 2]) == `NSL_CMD_DEPLOY) ? NSL_DEP : NSL_UNDEP)) // [RULE10]
      else $error("accepted command did not change state");
   dep_outputs_a: assert property ((r.st == NSL_DEP) |-> record_en && clock_lock_en && gps_cycle_en) // [RULE4]
      else $error("deployed outputs wrong");
   undep_outputs_a: assert property ((r.st == NSL_UNDEP) |-> !record_en && status_bcast_en) // [RULE5]
      else $error("undeployed outputs wrong");
   red_priority_a: assert property (red_busy |=> !led_white && !led_green && !led_yellow) // [RULE13]
      else $error("informational LED during red pattern");
   err_forever_a: assert property (r.err_hold |=> r.err_hold [*2]) // [RULE14]
      else $error("forever pattern was cleared");
   full_green_a: assert property (r.full_seen && !red_busy |=> led_green) // [RULE2]
      else $error("full charge without green");
   rec_green_a: assert property ((r.st == NSL_DEP) && test_pass && !red_busy
      ##1 (!red_busy && (r.st == NSL_DEP))
      |=> led_green) // [RULE12]
      else $error("passed test not shown green");
endmodule

// ===== verification/nsl_host.sv
/* Host model: offload, programming or field-tool side as an AHB-Lite master.
   Assumes one slave whose hreadyout comes back as hready. */
`timescale 1ns/1ps
module nsl_host (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // Bus idle at time zero; only whole words are ever sent.
   initial begin
      {hsel, haddr, htrans, hwrite} = '0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   /////////////////////////////////////////////////////////////////////////////
   // One single transfer; state commands of every source pass here.
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : ~hwdata;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~hwdata;
   endtask
endmodule

// ===== verification/nsl_ctrl_tb.sv
/* Testbench of nsl_ctrl: each scenario drives pins and commands, then judges.
   Assumes the host model and a ms tick of two cycles to keep the run short. */
`timescale 1ns/1ps
`include "nsl_map.svh"
module nsl_ctrl_tb_top;
   localparam int MS = 2;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic contact_volt, charge_cur, charge_full, test_pass, node_error, cmd_reject;
   logic power_hold, record_en, gps_cycle_en, clock_lock_en, status_bcast_en;
   logic led_green, led_white, led_yellow, led_red;
   int mismatches = 0;
   int check_count = 0;
   int c;
   wire [3:0] act = {record_en, gps_cycle_en, clock_lock_en, status_bcast_en};
   wire [3:0] leds = {led_red, led_yellow, led_white, led_green};
   /////////////////////////////////////////////////////////////////////////////
   // Clock of 5 ns period.
   always #2.5 hclk = ~hclk;
   // Host and design; hreadyout is the bus hready.
   nsl_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   nsl_ctrl #(.TICK_CYCLES(MS)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .contact_volt(contact_volt), .charge_cur(charge_cur),
      .charge_full(charge_full), .test_pass(test_pass), .node_error(node_error),
      .cmd_reject(cmd_reject), .power_hold(power_hold), .record_en(record_en),
      .gps_cycle_en(gps_cycle_en), .clock_lock_en(clock_lock_en),
      .status_bcast_en(status_bcast_en), .led_green(led_green),
      .led_white(led_white), .led_yellow(led_yellow), .led_red(led_red));
   /////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (mismatches == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Command write, then two edges for the new state to reach the pins.
   task automatic cmd(input logic [1:0] src, input logic [1:0] code);
      host.xfer(1'b1, {24'h0, `NSL_OFS_CMD}, {28'h0, src, code}, rd);
      cyc(2);
   endtask
   task automatic stat();
      host.xfer(1'b0, {24'h0, `NSL_OFS_STAT}, 32'h0, rd);
   endtask
   // Counts high cycles or rising edges; a pin already high counts as a rise.
   // LED index k: 0 green, 1 white, 2 yellow, 3 red.
   task automatic rises(input int k, input int n, input bit lvl);
      logic p;
      c = 0;
      p = 1'b0;
      repeat (n) begin
         @(posedge hclk);
         c += lvl ? (leds[k] === 1'b1) : (leds[k] === 1'b1 && p !== 1'b1);
         p = leds[k];
      end
   endtask
   /////////////////////////////////////////////////////////////////////////////
   task automatic t_modes();
      check({power_hold, act}, 5'h11);
      for (int s = 0; s < 3; s++) begin
         cmd(s[1:0], `NSL_CMD_DEPLOY);
         check(act, 4'hf);
         cmd(s[1:0], `NSL_CMD_UNDEPLOY);
         check(act, 4'h1);
      end
      host.xfer(1'b0, {24'h0, `NSL_OFS_CMD}, 32'h0, rd);
      check(rd[3:2], 2'h2);
      check({hresp, hreadyout}, 2'h1);
   endtask
   // Deployed and tested, shelved, then woken by a short contact voltage.
   task automatic t_bump();
      cmd(2'h1, `NSL_CMD_DEPLOY);
      test_pass <= 1'b1;
      cyc(1);
      test_pass <= 1'b0;
      cyc(3);
      check(led_green, 1'b1);
      cmd(2'h2, `NSL_CMD_SHELF);
      check({power_hold, act}, 5'h0);
      contact_volt <= 1'b1;
      cyc(8);
      contact_volt <= 1'b0;
      cyc(6);
      check({power_hold, act}, 5'h1f);
      rises(1, 980 * MS, 1'b0);
      check(c, 1);
      check(led_white, 1'b1);
      cyc(30 * MS);
      check(led_white, 1'b0);
   endtask
   // Shelved undeployed, woken by the charger, then charged to full.
   task automatic t_charge();
      cmd(2'h0, `NSL_CMD_UNDEPLOY);
      cmd(2'h0, `NSL_CMD_SHELF);
      {contact_volt, charge_cur} <= 2'h3;
      cyc(8);
      check({power_hold, act, led_white}, 6'h22);
      rises(2, 8000 * MS, 1'b1);
      check(c, 4000 * MS);
      charge_full <= 1'b1;
      cyc(100 * MS);
      check({led_green, led_yellow}, 2'h2);
      {contact_volt, charge_cur, charge_full} <= 3'h0;
      cyc(8);
      check(led_green, 1'b0);
   endtask
   // A refused deploy blinks red five times and keeps the state.
   task automatic t_fail();
      cmd_reject <= 1'b1;
      cmd(2'h1, `NSL_CMD_DEPLOY);
      cmd_reject <= 1'b0;
      rises(3, 10500 * MS, 1'b0);
      check(c, 5);
      stat();
      check({rd[15:8], act}, 12'h011);
      // An invalid source: shelving is ignored and a deploy fails again.
      cmd(2'h3, `NSL_CMD_SHELF);
      cmd(2'h3, `NSL_CMD_DEPLOY);
      stat();
      check({rd[15:8], rd[6], act}, 13'h051);
   endtask
   // A latched error keeps the slow red blink over later events.
   task automatic t_error();
      cmd(2'h2, `NSL_CMD_DEPLOY);
      node_error <= 1'b1;
      cyc(1);
      {node_error, test_pass} <= 2'h1;
      cyc(1);
      test_pass <= 1'b0;
      rises(3, 8000 * MS, 1'b1);
      check(c, 4000 * MS);
      check(led_green, 1'b0);
      stat();
      check(rd[5:4], 2'h3);
   endtask
   /////////////////////////////////////////////////////////////////////////////
   // Main sequence after 16 cycles of reset.
   initial begin
      {contact_volt, charge_cur, charge_full, test_pass, node_error, cmd_reject} <= 6'h0;
      cyc(16);
      hresetn <= 1'b1;
      cyc(1);
      t_modes();
      t_bump();
      t_charge();
      t_fail();
      t_error();
      finish_test();
   end
   // Watchdog, well beyond the expected 56000 cycles.
   initial begin
      cyc(70000);
      mismatches++;
      finish_test();
   end
endmodule
